// ===== hdl/caif_frontend.sv
// Purpose: coded audio master/slave serial inputs, sync and error-driven muting
// Assumes: decoder core reports lock, field class and crc/syntax results
// Notes: settings at REG_SETTINGS, status at REG_STATUS
// Summary of operation
// - master input, crystal timing: device picks sample rate, 44.1 kHz after reset
// - timing changes only on lock or on switching between inputs
// - slave input keeps last master sample rate; restored on return
// - errors: external flags, crc failure with protection, syntax errors
// - header/allocation/scfsi errors mute; scale factor error reuses previous
// - with crc active, allocation and scfsi validity come from crc and syntax checks, not from the external flag
// - force-crc setting treats protection as present whatever the header says
// - reset drops sync, mutes outputs, restores settings
// - stop: zero subbands, halt master requests, hold word select level
// - stop acts within half a sample period, loses sync, mutes until resync
// - unreliable data mutes and loses sync; master requests keep running
// - master data clock runs continuously at 768 kHz
// - word select toggles per request; 16 bits follow one period later
// - word select spacing is round(16*768/E) data clock periods
// - master error flag combined over each group of 8 bits
// - slave bits taken only in window; flag ignored outside, grouped per 8
// - first windowed bit after frame sync rise is the frame's first bit
// - select high: request pacing derived from external sample clock
`timescale 1ns/1ns
module caif_frontend (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic master_coded_data_i,
  input wire logic master_error_flag_i,
  output logic master_data_clock_o,
  output logic master_word_select_o,
  input wire logic slave_coded_data_i,
  input wire logic slave_error_flag_i,
  input wire logic slave_data_clock_i,
  input wire logic slave_burst_window_i,
  input wire logic slave_frame_sync_i,
  input wire logic external_sample_clock_in_i,
  input wire logic sample_clock_source_select_i,
  input wire logic input_select_slave_i,
  input wire logic stop_i,
  input wire logic unreliable_data_in_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic lock_i,
  input wire logic [8:0] lock_kbps_i,
  input wire logic [1:0] lock_rate_i,
  input wire logic frame_boundary_i,
  input wire logic field_valid_i,
  input wire logic [2:0] field_i,
  input wire logic field_flag_err_i,
  input wire logic protect_bit_i,
  input wire logic crc_fail_i,
  input wire logic syntax_err_i,
  output logic [7:0] byte_o,
  output logic byte_valid_o,
  output logic byte_err_o,
  output logic byte_first_o,
  output logic audio_mute_o,
  output logic zero_subband_o,
  output logic reuse_scalefactor_o,
  output logic sync_lost_o,
  output logic timing_change_o,
  output logic [1:0] sample_rate_o,
  output logic sck_from_ext_o
);
  typedef struct packed {
    logic [17:0] dacc;
    logic dclk;
    logic [17:0] eacc;
    logic ext_q;
    logic ws;
    logic [8:0] ws_cnt;
    logic [8:0] n_target;
    logic [4:0] burst_left;
    logic burst_wait;
    logic scl_q;
    logic fsy_q;
    logic sync_pend;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic err_acc;
    logic first_acc;
    logic [7:0] byte_d;
    logic byte_valid;
    logic byte_err;
    logic byte_first;
    caif_pkg::caif_lock_t sync;
    logic frame_mute;
    logic mute;
    logic zero_sub;
    logic reuse_sf;
    logic sync_lost;
    logic timing_change;
    caif_pkg::caif_fs_t rate;
    logic slave_q;
    logic sck_ext;
    logic [2:0] settings;
    logic [7:0] rdata;
  } caif_state_t;
  caif_state_t st;
  caif_state_t next_st;

  logic mdat_s, merr_s, scl_s, sdat_s, serr_s, win_s, fsy_s;
  logic ext_s, fsel_s, slave_s, stop_s, unreliable_data_in_s;
  logic [17:0] dsum, esum;
  logic fall, rise, ext_tick, tick, master_act, switched;
  logic take, bit_v, err_v, first_v, pend_now, use_pulse;
  logic crc_act, sel_alloc, flag_bad, bad;
  logic [14:0] quo;

  caif_sync2 #(.W(caif_pkg::SYNC_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .async_i({master_coded_data_i, master_error_flag_i, slave_data_clock_i,
              slave_coded_data_i, slave_error_flag_i, slave_burst_window_i,
              slave_frame_sync_i, external_sample_clock_in_i,
              sample_clock_source_select_i, input_select_slave_i, stop_i,
              unreliable_data_in_i}),
    .sync_o({mdat_s, merr_s, scl_s, sdat_s, serr_s, win_s, fsy_s, ext_s, fsel_s,
             slave_s, stop_s, unreliable_data_in_s})
  );

  always_comb begin
    next_st = st;
    rise = 1'b0;
    fall = 1'b0;
    ext_tick = 1'b0;
    take = 1'b0;
    bit_v = 1'b0;
    err_v = 1'b0;
    first_v = 1'b0;
    master_act = !slave_s;
    switched = slave_s != st.slave_q;
    use_pulse = st.settings[caif_pkg::SET_MODE_LO] | st.settings[caif_pkg::SET_MODE_HI];
    // fractional divider: average 768 kHz, jitter one reference cycle
    dsum = st.dacc + caif_pkg::DCLK_INC;
    if (dsum >= caif_pkg::DCLK_MOD) begin
      next_st.dacc = dsum - caif_pkg::DCLK_MOD;
      next_st.dclk = !st.dclk;
      rise = !st.dclk;
      fall = st.dclk;
    end else begin
      next_st.dacc = dsum;
    end
    // external sample clock scaled to the same nominal tick rate
    next_st.ext_q = ext_s;
    esum = st.eacc + caif_pkg::EXT_INC;
    if (ext_s && !st.ext_q) begin
      if (esum >= caif_pkg::EXT_MOD) begin
        next_st.eacc = esum - caif_pkg::EXT_MOD;
        ext_tick = 1'b1;
      end else begin
        next_st.eacc = esum;
      end
    end
    tick = fsel_s ? ext_tick : rise;
    next_st.slave_q = slave_s;
    next_st.sck_ext = slave_s | fsel_s;
    next_st.timing_change = lock_i | (switched & !fsel_s);
    // master burst: sample on falling edge, source shifts on the falling edge before
    if (master_act && !stop_s && fall && st.burst_left != 5'h0) begin
      if (st.burst_wait) begin
        next_st.burst_wait = 1'b0;
      end else begin
        take = 1'b1;
        bit_v = mdat_s;
        err_v = merr_s;
        next_st.burst_left = st.burst_left - 5'h1;
      end
    end
    // word select pacing; frozen level while stopped or on slave input
    if (!master_act || stop_s) begin
      next_st.burst_left = 5'h0;
      next_st.ws_cnt = 9'h0;
    end else if (tick) begin
      if (st.ws_cnt >= st.n_target - 9'h1) begin
        next_st.ws = !st.ws;
        next_st.ws_cnt = 9'h0;
        next_st.burst_left = caif_pkg::BURST_LEN;
        next_st.burst_wait = 1'b1;
      end else begin
        next_st.ws_cnt = st.ws_cnt + 9'h1;
      end
    end
    // slave input, sampled on the synchronised clock's rising edge
    next_st.scl_q = scl_s;
    pend_now = st.sync_pend | (fsy_s & !st.fsy_q);
    if (!master_act && scl_s && !st.scl_q) begin
      next_st.fsy_q = fsy_s;
      next_st.sync_pend = pend_now & !win_s;
      if (win_s && !stop_s) begin
        take = 1'b1;
        bit_v = sdat_s;
        err_v = serr_s;
        first_v = pend_now & use_pulse;
      end
    end
    // byte assembly, one reliability flag per 8 bits
    next_st.byte_valid = 1'b0;
    if (switched || stop_s) begin
      next_st.bit_cnt = 3'h0;
      next_st.err_acc = 1'b0;
      next_st.first_acc = 1'b0;
    end else if (take && first_v) begin
      // realign: a partial byte before a frame start is dropped
      next_st.shift = {7'h0, bit_v};
      next_st.bit_cnt = 3'h1;
      next_st.err_acc = err_v;
      next_st.first_acc = 1'b1;
    end else if (take) begin
      next_st.shift = {st.shift[6:0], bit_v};
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      next_st.err_acc = st.err_acc | err_v;
      if (st.bit_cnt == 3'h7) begin
        next_st.byte_d = {st.shift[6:0], bit_v};
        next_st.byte_err = st.err_acc | err_v;
        next_st.byte_first = st.first_acc;
        next_st.byte_valid = 1'b1;
        next_st.err_acc = 1'b0;
        next_st.first_acc = 1'b0;
      end
    end
    // error classification for the field the decoder is parsing
    crc_act = st.settings[caif_pkg::SET_FORCE_CRC] | protect_bit_i;
    sel_alloc = field_i == caif_pkg::FLD_ALLOC || field_i == caif_pkg::FLD_SCFSI;
    flag_bad = (crc_act && sel_alloc) ? crc_fail_i : field_flag_err_i;
    bad = field_valid_i & (field_i == caif_pkg::FLD_HEADER | sel_alloc) &
          (flag_bad | syntax_err_i);
    next_st.reuse_sf = field_valid_i & (field_i == caif_pkg::FLD_SCALEF) &
                       (field_flag_err_i | syntax_err_i);
    if (frame_boundary_i) begin
      next_st.frame_mute = 1'b0;
    end
    if (bad) begin
      next_st.frame_mute = 1'b1;
    end
    // synchronisation state
    quo = (caif_pkg::N_NUM + 15'(lock_kbps_i >> 1)) / 15'(lock_kbps_i);
    next_st.sync_lost = 1'b0;
    if (stop_s || unreliable_data_in_s) begin
      next_st.sync_lost = st.sync == caif_pkg::LOCKED;
      next_st.sync = caif_pkg::HUNT;
    end else if (lock_i) begin
      next_st.sync = caif_pkg::LOCKED;
      // free format reports zero and leaves the pacing alone
      if (master_act && lock_kbps_i != 9'h0) begin
        next_st.n_target = quo[8:0];
      end
      if (master_act && !fsel_s && lock_rate_i <= 2'h2) begin
        next_st.rate = caif_pkg::caif_fs_t'(lock_rate_i);
      end
    end
    next_st.mute = next_st.sync != caif_pkg::LOCKED | stop_s | unreliable_data_in_s |
                   next_st.frame_mute;
    next_st.zero_sub = stop_s;
    // register port
    next_st.rdata = 8'h0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        caif_pkg::REG_SETTINGS: next_st.rdata = {5'h0, st.settings};
        caif_pkg::REG_STATUS: next_st.rdata = {3'h0, st.sync == caif_pkg::LOCKED,
                                               st.mute, st.rate, st.slave_q};
        default: next_st.rdata = 8'h0;
      endcase
    end
    if (reg_wr_i && reg_addr_i == caif_pkg::REG_SETTINGS) begin
      next_st.settings = reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.n_target <= caif_pkg::N_DEFAULT;
      st.rate <= caif_pkg::RST_RATE;
      st.sync <= caif_pkg::HUNT;
      st.mute <= 1'b1;
      st.settings <= caif_pkg::SET_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign master_data_clock_o = st.dclk;
  assign master_word_select_o = st.ws;
  assign reg_rdata_o = st.rdata;
  assign byte_o = st.byte_d;
  assign byte_valid_o = st.byte_valid;
  assign byte_err_o = st.byte_err;
  assign byte_first_o = st.byte_first;
  assign audio_mute_o = st.mute;
  assign zero_subband_o = st.zero_sub;
  assign reuse_scalefactor_o = st.reuse_sf;
  assign sync_lost_o = st.sync_lost;
  assign timing_change_o = st.timing_change;
  assign sample_rate_o = st.rate;
  assign sck_from_ext_o = st.sck_ext;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  reset_state_a: assert property ($rose(resetn_i) |-> st.mute && st.sync == caif_pkg::HUNT
    && st.rate == caif_pkg::FS_44K1 && st.n_target == caif_pkg::N_DEFAULT)
    else $error("state after reset not at defaults");
  ws_hold_a: assert property (stop_s && $past(stop_s) |-> $stable(st.ws))
    else $error("word select moved while stopped");
  dclk_rate_a: assert property ($changed(st.dclk) |-> ##[65:66] $changed(st.dclk))
    else $error("data clock half period out of range");
  burst_len_a: assert property ($changed(st.ws) |-> st.burst_left == caif_pkg::BURST_LEN
    && st.burst_wait)
    else $error("burst not armed at word select toggle");
  unreliable_data_in_lost_a: assert property (unreliable_data_in_s |=> st.sync == caif_pkg::HUNT && st.mute)
    else $error("unreliable data did not drop sync");
  stop_lost_a: assert property (stop_s && st.sync == caif_pkg::LOCKED |=> st.sync_lost
    ##1 !st.sync_lost)
    else $error("stop did not flag sync loss once");
  rate_keep_a: assert property (slave_s && $past(slave_s) |-> $stable(st.rate))
    else $error("sample rate changed on slave input");
  window_gate_a: assert property (!master_act && !win_s && !switched && !stop_s
    |=> $stable(st.bit_cnt))
    else $error("slave bit taken outside window");
  crc_only_a: assert property (field_valid_i && field_i == caif_pkg::FLD_ALLOC && crc_act
    && !crc_fail_i && !syntax_err_i && !st.frame_mute |=> !st.frame_mute)
    else $error("external flag muted crc-protected field");
endmodule // caif_frontend

// ===== hdl/caif_pkg.sv
// Purpose: shared constants and types of the coded audio input front end
// Assumes: 100 MHz reference clock
// Notes: reg offsets are word indices on the plain register port
package caif_pkg;
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned DCLK_KHZ = 768;
  // half-period accumulator: two toggles per data clock period
  localparam logic [17:0] DCLK_MOD = 18'(CLK_KHZ);
  localparam logic [17:0] DCLK_INC = 18'(2 * DCLK_KHZ);
  // external sample clock assumed 256 x 44.1 kHz, counted in 100 Hz units
  localparam int unsigned EXT_FS_MULT = 256;
  localparam int unsigned FS_NOM_HZ = 44100;
  localparam logic [17:0] EXT_MOD = 18'(EXT_FS_MULT * FS_NOM_HZ / 100);
  localparam logic [17:0] EXT_INC = 18'(DCLK_KHZ * 10);
  localparam int unsigned BURST_BITS = 16;
  localparam logic [4:0] BURST_LEN = 5'(BURST_BITS);
  localparam int unsigned DEFAULT_KBPS = 384;
  localparam logic [14:0] N_NUM = 15'(BURST_BITS * DCLK_KHZ);
  localparam logic [8:0] N_DEFAULT = 9'((BURST_BITS * DCLK_KHZ + DEFAULT_KBPS / 2) / DEFAULT_KBPS);
  // frame field codes reported by the decoder core
  localparam logic [2:0] FLD_HEADER = 3'h0;
  localparam logic [2:0] FLD_ALLOC = 3'h1;
  localparam logic [2:0] FLD_SCFSI = 3'h2;
  localparam logic [2:0] FLD_SCALEF = 3'h3;
  // register port
  localparam logic [1:0] REG_SETTINGS = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam int unsigned SET_FORCE_CRC = 0;
  localparam int unsigned SET_MODE_LO = 1;
  localparam int unsigned SET_MODE_HI = 2;
  localparam logic [2:0] SET_RESET = 3'h0;
  localparam int unsigned SYNC_W = 12;
  typedef enum logic [1:0] {FS_32K, FS_44K1, FS_48K} caif_fs_t;
  typedef enum logic {HUNT, LOCKED} caif_lock_t;
  localparam caif_fs_t RST_RATE = FS_44K1;
endpackage

// ===== hdl/caif_sync2.sv
// Purpose: two-flop synchroniser bank for pins entering the reference clock domain
// Assumes: inputs are levels slower than the reference clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module caif_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } caif_sync2_t;
  caif_sync2_t st;
  caif_sync2_t next_st;

  always_comb begin
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.s2;
endmodule // caif_sync2

// ===== sim/caif_frontend_bench.sv
// Purpose: self-checking bench of the coded audio input front end
// Assumes: decoder core side is driven directly by the bench
// Notes: master source is a model, slave pins are driven by tasks
`timescale 1ns/1ns
module caif_frontend_bench;
  logic clk = 1'b0, rstn = 1'b0, extclk = 1'b0, sdata = 1'b0, serr = 1'b0, sclk = 1'b0;
  logic swin = 1'b0, ssync = 1'b0, ssel = 1'b0, islave = 1'b0, stop = 1'b0, unreliable_data_in = 1'b0;
  logic wr = 1'b0, rd = 1'b0, lock = 1'b0, fb = 1'b0, fv = 1'b0, ferr = 1'b0, prot = 1'b0;
  logic crc = 1'b0, syn = 1'b0, mdata, merr, dclk, ws, bv, berr, bfirst, mute, zsub;
  logic reuse, lost, sext, dq, wq, seen, lost_seen = 1'b0, chk_m = 1'b1, sf, se, tchg;
  logic [1:0] addr = 2'h0, lrate = 2'h0, rate;
  logic [2:0] fld = 3'h0;
  logic [7:0] wdata = 8'h0, rdata, byte_v, sb, nb = 8'h0, r;
  logic [8:0] kbps = 9'h0;
  int fails = 0, check_count = 0, hc, rises, gap, toggles, ns = 0, t, i;
  logic [1:0] e;
  caif_frontend DUT (.ref_clk_i(clk), .resetn_i(rstn), .master_coded_data_i(mdata),
    .master_error_flag_i(merr), .master_data_clock_o(dclk), .master_word_select_o(ws),
    .slave_coded_data_i(sdata), .slave_error_flag_i(serr), .slave_data_clock_i(sclk),
    .slave_burst_window_i(swin), .slave_frame_sync_i(ssync),
    .external_sample_clock_in_i(extclk), .sample_clock_source_select_i(ssel),
    .input_select_slave_i(islave), .stop_i(stop), .unreliable_data_in_i(unreliable_data_in),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .lock_i(lock), .lock_kbps_i(kbps), .lock_rate_i(lrate), .frame_boundary_i(fb),
    .field_valid_i(fv), .field_i(fld), .field_flag_err_i(ferr), .protect_bit_i(prot),
    .crc_fail_i(crc), .syntax_err_i(syn), .byte_o(byte_v), .byte_valid_o(bv),
    .byte_err_o(berr), .byte_first_o(bfirst), .audio_mute_o(mute), .zero_subband_o(zsub),
    .reuse_scalefactor_o(reuse), .sync_lost_o(lost), .timing_change_o(tchg),
    .sample_rate_o(rate), .sck_from_ext_o(sext));
  caif_src_model SRC (.ref_clk_i(clk), .resetn_i(rstn), .master_data_clock_i(dclk),
    .master_word_select_i(ws), .master_coded_data_o(mdata), .master_error_flag_o(merr));
  always #5 clk = ~clk;
  // roughly 256 x 44.1 kHz, phase unrelated to the reference clock
  always #44 extclk = ~extclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    check_count++;
    if (got !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] want);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, want, "read data");
  endtask
  task automatic do_lock(input logic [8:0] k, input logic [1:0] rc);
    @(posedge clk);
    lock <= 1'b1;
    kbps <= k;
    lrate <= rc;
    @(posedge clk);
    lock <= 1'b0;
    fb <= 1'b1;
    @(negedge clk);
    chk(8'(tchg), 8'h1, "timing change on lock");
    @(posedge clk);
    fb <= 1'b0;
  endtask
  task automatic ws_gap(input int lo, input int hi);
    t = toggles;
    // one toggle per call: the interval that ends there is measured whole
    for (i = 0; i < 20000 && toggles < t + 1; i++) @(posedge clk);
    if (i == 20000) begin
      fails++;
      give_verdict();
    end
    chk(8'(gap >= lo && gap <= hi), 8'h1, "request spacing");
  endtask
  task automatic sbit(input logic d, input logic w, input logic s, input logic ef);
    @(posedge clk);
    sclk <= 1'b0;
    sdata <= d;
    swin <= w;
    ssync <= s;
    serr <= ef;
    tick(70); // 141 cycles a bit stays below 768 kHz
    sclk <= 1'b1;
    tick(70);
  endtask
  // mute, reuse expected for one reported field
  function automatic logic [1:0] fx(int f, logic fl, logic cr, logic act, logic sy);
    logic x;
    x = sy | ((f == 1 || f == 2) ? (act ? cr : fl) : fl);
    if (f < 3) return {x, 1'b0};
    if (f == 3) return {1'b0, x};
    return 2'b00;
  endfunction
  task automatic field(input int f, input logic fl, input logic pr, input logic cr,
                       input logic sy, input logic fc);
    reg_wr(2'h0, {7'h0, fc});
    @(posedge clk);
    fv <= 1'b1;
    fld <= 3'(f);
    ferr <= fl;
    prot <= pr;
    crc <= cr;
    syn <= sy;
    @(posedge clk);
    fv <= 1'b0;
    @(negedge clk);
    e = fx(f, fl, cr, pr | fc, sy);
    chk(8'(mute), 8'(e[1]), "field mute");
    chk(8'(reuse), 8'(e[0]), "scale factor reuse");
    @(posedge clk);
    fb <= 1'b1;
    @(posedge clk);
    fb <= 1'b0;
  endtask
  always @(posedge clk) begin
    dq <= dclk;
    wq <= ws;
    if (!rstn) begin
      seen <= 1'b0;
      rises <= 0;
      toggles <= 0;
    end else begin
      if (dclk !== dq) begin
        if (seen) chk(8'(hc == 65 || hc == 66), 8'h1, "data clock half period");
        hc <= 1;
        seen <= 1'b1;
      end else hc <= hc + 1;
      if (ws !== wq) begin
        gap <= rises + int'(dclk & !dq);
        rises <= 0;
        toggles <= toggles + 1;
      end else rises <= rises + int'(dclk & !dq);
      if (lost) lost_seen <= 1'b1;
      if (bv && chk_m) begin
        chk(byte_v, nb, "master byte");
        chk(8'(berr), 8'(nb[1:0] == 2'h2), "master byte flag");
        nb <= nb + 8'h1;
      end
      if (bv && !chk_m) begin
        sb <= byte_v;
        sf <= bfirst;
        se <= berr;
        ns <= ns + 1;
      end
    end
  end
  initial begin
    #900000;
    fails++;
    give_verdict();
  end
  initial begin
    void'($urandom(10));
    tick(6);
    rstn <= 1'b1;
    @(negedge clk);
    chk(8'(mute), 8'h1, "mute after reset");
    chk(8'(rate), 8'h1, "rate after reset");
    reg_rd(2'h1, 8'h0a);
    reg_rd(2'h0, 8'h00);
    reg_wr(2'h1, 8'hff);
    reg_rd(2'h3, 8'h00);
    reg_wr(2'h0, 8'h05);
    reg_rd(2'h0, 8'h05);
    ws_gap(30, 34);
    ws_gap(30, 34);
    do_lock(9'd256, 2'h2);
    ws_gap(0, 999);
    ws_gap(46, 50);
    chk(8'(rate), 8'h2, "locked rate");
    chk(8'(mute), 8'h0, "audio after lock");
    for (int f = 0; f < 8; f++) field(f, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    field(1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    field(2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    repeat (30) begin
      r = 8'($urandom);
      field(r[2:0], r[3], r[4], r[5] & (r[2:0] == 3'h1 || r[2:0] == 3'h2), r[6], r[7]);
    end
    lost_seen = 1'b0;
    unreliable_data_in <= 1'b1;
    // look at settled values only; the last field may still show its mute
    @(negedge clk);
    for (i = 0; i < 1200 && mute !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    chk(8'(mute), 8'h1, "unreliable mute");
    chk(8'(lost_seen), 8'h1, "unreliable sync loss");
    ws_gap(46, 50);
    unreliable_data_in <= 1'b0;
    // the pin needs its synchroniser delay before a lock can be honoured
    tick(4);
    do_lock(9'd256, 2'h2);
    chk_m = 1'b0;
    lost_seen = 1'b0;
    stop <= 1'b1;
    @(negedge clk);
    for (i = 0; i < 1200 && zsub !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    chk(8'(zsub), 8'h1, "stop zero subbands");
    chk(8'(lost_seen), 8'h1, "stop sync loss");
    r[0] = ws;
    t = toggles;
    tick(8000);
    chk(8'(ws), 8'(r[0]), "word select held");
    chk(8'(toggles == t), 8'h1, "requests halted");
    stop <= 1'b0;
    tick(20);
    chk(8'(mute), 8'h1, "muted until sync");
    reg_wr(2'h0, 8'h02);
    islave <= 1'b1;
    tick(20);
    t = ns;
    sbit(1'b0, 1'b0, 1'b0, 1'b1);
    sbit(1'b1, 1'b0, 1'b1, 1'b1);
    for (int b = 7; b >= 0; b--) sbit(r[b], 1'b1, 1'b1, b == 6);
    tick(10);
    chk(sb, r, "slave first byte");
    chk(8'(sf), 8'h1, "slave frame start");
    chk(8'(se), 8'h1, "slave byte flag");
    r = 8'($urandom);
    for (int b = 7; b >= 0; b--) begin
      if (b == 3) sbit(~r[b], 1'b0, 1'b0, 1'b1);
      sbit(r[b], 1'b1, 1'b0, 1'b0);
    end
    tick(10);
    chk(sb, r, "slave windowed byte");
    chk(8'(sf), 8'h0, "slave mid frame");
    chk(8'(se), 8'h0, "slave flag outside window");
    chk(8'(ns - t), 8'h2, "slave byte count");
    do_lock(9'd128, 2'h0);
    islave <= 1'b0;
    tick(20);
    chk(8'(rate), 8'h2, "master rate restored");
    ws_gap(0, 999);
    ws_gap(46, 50);
    ssel <= 1'b1;
    tick(20);
    chk(8'(sext), 8'h1, "external pacing");
    ws_gap(0, 999);
    ws_gap(46, 50);
    give_verdict();
  end
endmodule // caif_frontend_bench

// ===== sim/caif_src_model.sv
// Purpose: behavioural coded-data source on the master input
// Assumes: byte stream counts up from 0, error flag on bit 3 of odd words
// Notes: idle data shows the inverse of the last bit so a stale value never passes
`timescale 1ns/1ns
module caif_src_model (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic master_data_clock_i,
  input wire logic master_word_select_i,
  output logic master_coded_data_o,
  output logic master_error_flag_o
);
  logic dq, wq, active;
  logic [4:0] cnt;
  logic [7:0] widx;
  logic [15:0] word;
  // two bytes per burst keeps every frame start on bit 1 or bit 9
  assign word = {widx[6:0], 1'b0, widx[6:0], 1'b1};
  always @(posedge ref_clk_i) begin
    dq <= master_data_clock_i;
    wq <= master_word_select_i;
    if (!resetn_i) begin
      active <= 1'b0;
      cnt <= 5'h0;
      widx <= 8'h0;
      master_coded_data_o <= 1'b0;
      master_error_flag_o <= 1'b1;
    end else if (master_word_select_i != wq) begin
      active <= 1'b1;
      cnt <= 5'h0;
    end else if (dq && !master_data_clock_i && active) begin
      // bit launched on a fall is taken at the next fall: first fall carries nothing
      if (cnt < 5'h10) begin
        master_coded_data_o <= word[4'hf - cnt[3:0]];
        master_error_flag_o <= (cnt == 5'h3) && widx[0];
        cnt <= cnt + 5'h1;
      end else begin
        master_coded_data_o <= ~master_coded_data_o;
        master_error_flag_o <= 1'b1;
        active <= 1'b0;
        widx <= widx + 8'h1;
      end
    end
  end
endmodule // caif_src_model
